// ==== design/strap_config_decoder.sv ====
`timescale 1ns/100ps
module strap_config_decoder
  import strap_config_pkg::*;
(
  // Clock and reset
  input logic clk_sys_in,
  input logic sys_rst_in,
  // Board control pins
  input logic op_enable_in,
  input logic sig_detect_enable_in,
  input logic control_mode_select_in,
  input logic address_bit_high_in,
  input tri_sense_s deemph_select_in,
  input tri_sense_s equalizer_select_addr_low_in,
  input tri_sense_s transmit_termination_select_in,
  input tri_sense_s lane_swap_polarity_select_in,
  // Local control port pins
  input logic local_ctrl_clock_in,
  output logic local_ctrl_clock_out,
  output logic local_ctrl_clock_oe_n_out,
  input logic local_ctrl_data_in,
  output logic local_ctrl_data_out,
  output logic local_ctrl_data_oe_n_out,
  // Datapath status
  input logic input_clock_valid_in,
  input logic retimer_mode_in,
  input logic rate_above_2g_in,
  // Control port engine side
  output logic i2c_scl_out,
  output logic i2c_sda_out,
  input logic i2c_sda_drive_low_in,
  input logic i2c_cfg_wr_in,
  input i2c_cfg_s i2c_cfg_in,
  // Decoded settings
  output logic power_down_out,
  output logic standby_out,
  output logic detector_on_out,
  output logic rx_term_on_out,
  output deemph_e deemph_out,
  output eq_mode_e eq_mode_out,
  output logic strap_reserved_out,
  output logic tx_term_on_out,
  output logic lane_swap_out,
  output logic lane_invert_out,
  output logic i2c_mode_out,
  output logic [1:0] i2c_addr_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    pin_s sync1;
    pin_s sync2;
    logic en_prev;
    mode_e mode;
    logic [SETTLE_W-1:0] settle_cnt;
    logic mode_lat;
    logic addr_hi_lat;
    logic addr_lo_lat;
    tri_e deemph_lat;
    tri_e eq_lat;
    tri_e term_lat;
    tri_e swap_lat;
    i2c_cfg_s i2c_cfg;
    logic power_down;
    logic standby;
    logic detector_on;
    logic rx_term_on;
    deemph_e deemph;
    eq_mode_e eq;
    logic reserved;
    logic tx_term_on;
    logic lane_swap;
    logic lane_invert;
    logic i2c_mode;
    logic [1:0] i2c_addr;
    logic scl_fwd;
    logic sda_fwd;
    logic sda_oe_n;
    logic scl_oe_n;
    logic pin_level;
  } state_s;

  state_s state_reg;
  state_s state_next;
  pin_s pins;
  logic enable_fall;
  logic running;
  logic port_active;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin gathering

  assign pins.op_en = op_enable_in;
  assign pins.sig_en = sig_detect_enable_in;
  assign pins.mode_sel = control_mode_select_in;
  assign pins.addr_hi = address_bit_high_in;
  assign pins.clk_valid = input_clock_valid_in;
  assign pins.scl = local_ctrl_clock_in;
  assign pins.sda = local_ctrl_data_in;
  assign pins.deemph = deemph_select_in;
  assign pins.eq = equalizer_select_addr_low_in;
  assign pins.term = transmit_termination_select_in;
  assign pins.swap = lane_swap_polarity_select_in;

  assign enable_fall = state_reg.en_prev && !state_reg.sync2.op_en;
  assign running = (state_reg.mode == ST_RUN) || (state_reg.mode == ST_STANDBY);
  assign port_active = running && state_reg.mode_lat;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    state_next = state_reg;
    // Only sync2 is read by logic; sync1 feeds sync2 alone
    state_next.sync1 = pins;
    state_next.sync2 = state_reg.sync1;
    state_next.en_prev = state_reg.sync2.op_en;

    case (state_reg.mode)
      ST_DOWN:
      begin
        if (state_reg.sync2.op_en)
        begin
          state_next.mode = ST_SAMPLE;
          state_next.settle_cnt = SETTLE_LOAD;
        end
      end
      ST_SAMPLE:
      begin
        if (state_reg.settle_cnt == SETTLE_DONE)
        begin
          // Straps frozen here; later pin noise cannot disturb the settings
          state_next.mode_lat = state_reg.sync2.mode_sel;
          state_next.addr_hi_lat = state_reg.sync2.addr_hi;
          state_next.addr_lo_lat = state_reg.sync2.eq.hi;
          state_next.deemph_lat = tri_decode(state_reg.sync2.deemph);
          state_next.eq_lat = tri_decode(state_reg.sync2.eq);
          state_next.term_lat = tri_decode(state_reg.sync2.term);
          state_next.swap_lat = tri_decode(state_reg.sync2.swap);
          state_next.mode = ST_RUN;
        end
        else
        begin
          state_next.settle_cnt = state_reg.settle_cnt - 1'b1;
        end
      end
      ST_RUN:
      begin
        if (state_reg.sync2.sig_en && !state_reg.sync2.clk_valid)
        begin
          state_next.mode = ST_STANDBY;
        end
      end
      ST_STANDBY:
      begin
        if (!state_reg.sync2.sig_en || state_reg.sync2.clk_valid)
        begin
          state_next.mode = ST_RUN;
        end
      end
      default:
      begin
        state_next.mode = ST_DOWN;
      end
    endcase

    // Writes land only in port mode, so straps keep priority otherwise
    if (i2c_cfg_wr_in && port_active)
    begin
      state_next.i2c_cfg = i2c_cfg_in;
    end

    if (!state_reg.sync2.op_en)
    begin
      state_next.mode = ST_DOWN;
    end

    // Reset wins over a write in the same cycle
    if (enable_fall)
    begin
      state_next.mode = ST_DOWN;
      state_next.i2c_cfg = I2C_CFG_RESET;
      state_next.mode_lat = 1'b0;
      state_next.addr_hi_lat = 1'b0;
      state_next.addr_lo_lat = 1'b0;
      state_next.deemph_lat = TRI_MID;
      state_next.eq_lat = TRI_MID;
      state_next.term_lat = TRI_MID;
      state_next.swap_lat = TRI_MID;
    end

    //////////////////////////////////////////////////////////////////////////////
    // Decoded outputs

    state_next.power_down = !running;
    // Gated by the detector enable so standby never disagrees with termination
    state_next.standby = (state_reg.mode == ST_STANDBY) && state_reg.sync2.sig_en;
    state_next.detector_on = running && state_reg.sync2.sig_en;
    // Termination drops whenever the detector enable is high and the mode is not ST_RUN
    state_next.rx_term_on = !state_reg.sync2.sig_en || (state_reg.mode == ST_RUN);

    state_next.reserved = 1'b0;
    if (state_reg.mode_lat)
    begin
      state_next.deemph = state_reg.i2c_cfg.deemph;
      state_next.eq = state_reg.i2c_cfg.eq;
    end
    else
    begin
      case (state_reg.deemph_lat)
        TRI_LOW: state_next.deemph = DEEMPH_NEG2DB;
        TRI_HIGH:
        begin
          // Reserved level: flagged and held at the unemphasised setting
          state_next.deemph = DEEMPH_0DB;
          state_next.reserved = 1'b1;
        end
        default: state_next.deemph = DEEMPH_0DB;
      endcase
      case (state_reg.eq_lat)
        TRI_LOW: state_next.eq = EQ_FIXED_7P5DB;
        TRI_HIGH: state_next.eq = EQ_FIXED_14DB;
        default: state_next.eq = EQ_ADAPTIVE;
      endcase
    end

    case (state_reg.term_lat)
      TRI_HIGH: state_next.tx_term_on = 1'b0;
      TRI_LOW: state_next.tx_term_on = 1'b1;
      default: state_next.tx_term_on = rate_above_2g_in;
    endcase

    state_next.lane_swap = (state_reg.swap_lat == TRI_LOW);
    state_next.lane_invert = (state_reg.swap_lat == TRI_HIGH) && retimer_mode_in;
    // Same delay as power down, so mode and address move only across it
    state_next.i2c_mode = state_reg.mode_lat;
    state_next.i2c_addr = {state_reg.addr_hi_lat, state_reg.addr_lo_lat};

    //////////////////////////////////////////////////////////////////////////////
    // Local control port pins

    // Outside port mode the engine sees an idle bus and the pins stay released
    state_next.scl_fwd = port_active ? state_reg.sync2.scl : 1'b1;
    state_next.sda_fwd = port_active ? state_reg.sync2.sda : 1'b1;
    state_next.sda_oe_n = !(port_active && i2c_sda_drive_low_in);
    state_next.scl_oe_n = 1'b1;
    state_next.pin_level = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= '0;
      state_reg.mode <= ST_DOWN;
      state_reg.deemph_lat <= TRI_MID;
      state_reg.eq_lat <= TRI_MID;
      state_reg.term_lat <= TRI_MID;
      state_reg.swap_lat <= TRI_MID;
      state_reg.i2c_cfg <= I2C_CFG_RESET;
      state_reg.power_down <= 1'b1;
      state_reg.rx_term_on <= 1'b1;
      state_reg.scl_fwd <= 1'b1;
      state_reg.sda_fwd <= 1'b1;
      state_reg.sda_oe_n <= 1'b1;
      state_reg.scl_oe_n <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign power_down_out = state_reg.power_down;
  assign standby_out = state_reg.standby;
  assign detector_on_out = state_reg.detector_on;
  assign rx_term_on_out = state_reg.rx_term_on;
  assign deemph_out = state_reg.deemph;
  assign eq_mode_out = state_reg.eq;
  assign strap_reserved_out = state_reg.reserved;
  assign tx_term_on_out = state_reg.tx_term_on;
  assign lane_swap_out = state_reg.lane_swap;
  assign lane_invert_out = state_reg.lane_invert;
  assign i2c_mode_out = state_reg.i2c_mode;
  assign i2c_addr_out = state_reg.i2c_addr;
  assign i2c_scl_out = state_reg.scl_fwd;
  assign i2c_sda_out = state_reg.sda_fwd;
  assign local_ctrl_clock_out = state_reg.pin_level;
  assign local_ctrl_clock_oe_n_out = state_reg.scl_oe_n;
  assign local_ctrl_data_out = state_reg.pin_level;
  assign local_ctrl_data_oe_n_out = state_reg.sda_oe_n;

endmodule : strap_config_decoder

// ==== design/strap_config_pkg.sv ====
package strap_config_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  // Time the strap pins get to settle after the enable pin rises
  localparam int STRAP_SETTLE_NS = 2000;
  localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 5;
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(STRAP_SETTLE_CYCLES - 1);
  localparam logic [SETTLE_W-1:0] SETTLE_DONE = 5'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Three-level pin sense: hi above the high threshold, lo below the low one
  typedef struct packed {
    logic hi;
    logic lo;
  } tri_sense_s;

  typedef enum logic [2:0] {
    TRI_LOW = 3'h1,
    TRI_MID = 3'h2,
    TRI_HIGH = 3'h4
  } tri_e;

  typedef enum logic [3:0] {
    ST_DOWN = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_RUN = 4'h4,
    ST_STANDBY = 4'h8
  } mode_e;

  typedef enum logic [1:0] {
    DEEMPH_0DB = 2'h0,
    DEEMPH_NEG2DB = 2'h1
  } deemph_e;

  typedef enum logic [1:0] {
    EQ_ADAPTIVE = 2'h0,
    EQ_FIXED_7P5DB = 2'h1,
    EQ_FIXED_14DB = 2'h2
  } eq_mode_e;

  // Settings written by the local control port engine
  typedef struct packed {
    deemph_e deemph;
    eq_mode_e eq;
  } i2c_cfg_s;

  localparam i2c_cfg_s I2C_CFG_RESET = '{deemph: DEEMPH_0DB, eq: EQ_ADAPTIVE};

  // All pins that arrive from the board
  typedef struct packed {
    logic op_en;
    logic sig_en;
    logic mode_sel;
    logic addr_hi;
    logic clk_valid;
    logic scl;
    logic sda;
    tri_sense_s deemph;
    tri_sense_s eq;
    tri_sense_s term;
    tri_sense_s swap;
  } pin_s;

  // Both thresholds tripped at once cannot be a clean drive, so it reads as open
  function automatic tri_e tri_decode(input tri_sense_s s);
    tri_e r;
    r = TRI_MID;
    if (s.hi && !s.lo)
    begin
      r = TRI_HIGH;
    end
    else if (s.lo && !s.hi)
    begin
      r = TRI_LOW;
    end
    return r;
  endfunction : tri_decode

endpackage : strap_config_pkg

// ==== bench/strap_board.sv ====
`timescale 1ns/100ps
module strap_board
  import strap_config_pkg::*;
(
  // Requests
  input logic clk_in,
  input logic port_mode_in,
  input logic [1:0] addr_in,
  input tri_e lvl_in [4],
  // Pins
  output logic addr_hi_out,
  output tri_sense_s sense_out [4]
);
  logic flip_reg = 1'b0;
  always @(posedge clk_in)
    flip_reg <= ~flip_reg;
  // Open pins wander, so no stale sense level can pass
  always_comb
  begin
    foreach (sense_out[i])
      sense_out[i] = lvl_in[i] == TRI_MID ? {flip_reg, flip_reg} : {lvl_in[i] == TRI_HIGH, lvl_in[i] == TRI_LOW};
    if (port_mode_in)
      sense_out[1] = {addr_in[0], !addr_in[0]};
    addr_hi_out = port_mode_in && addr_in[1];
  end
endmodule : strap_board

// ==== bench/strap_config_monitor.sv ====
`timescale 1ns/100ps
module strap_config_monitor
  import strap_config_pkg::*;
(
  // Clock and reset
  input logic clk_sys_in,
  input logic sys_rst_in,
  // Pins
  input logic op_enable_in,
  input logic sig_detect_enable_in,
  input logic retimer_mode_in,
  input logic i2c_cfg_wr_in,
  input i2c_cfg_s i2c_cfg_in,
  // Settings
  input logic power_down_out,
  input logic standby_out,
  input logic rx_term_on_out,
  input deemph_e deemph_out,
  input eq_mode_e eq_mode_out,
  input logic lane_swap_out,
  input logic lane_invert_out,
  input logic i2c_mode_out,
  input logic [1:0] i2c_addr_out,
  input logic i2c_scl_out,
  input logic i2c_sda_out,
  input logic local_ctrl_data_oe_n_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  ////////////////////
  property p_pd;
    !op_enable_in [*5] |-> power_down_out;
  endproperty
  a_pd: assert property (p_pd) else $error("still running");
  property p_rx;
    !sig_detect_enable_in [*4] |-> rx_term_on_out;
  endproperty
  a_rx: assert property (p_rx) else $error("termination off");
  property p_sb;
    standby_out |-> !rx_term_on_out && !power_down_out;
  endproperty
  a_sb: assert property (p_sb) else $error("bad standby");
  property p_inv;
    lane_invert_out |-> $past(retimer_mode_in) && !lane_swap_out;
  endproperty
  a_inv: assert property (p_inv) else $error("bad invert");
  // Latched settings may only move across a power down
  property p_hold;
    !power_down_out [*2] |-> $stable(lane_swap_out) && $stable(i2c_addr_out) && $stable(i2c_mode_out);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_strap;
    !i2c_mode_out && !power_down_out ##1 !power_down_out |-> $stable(deemph_out) && $stable(eq_mode_out);
  endproperty
  a_strap: assert property (p_strap) else $error("strap overridden");
  property p_wr;
    i2c_mode_out && i2c_cfg_wr_in ##1 !power_down_out [*2] |-> {deemph_out, eq_mode_out} == $past(i2c_cfg_in, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_port;
    !i2c_mode_out |-> i2c_scl_out && i2c_sda_out && local_ctrl_data_oe_n_out;
  endproperty
  a_port: assert property (p_port) else $error("port active");
  c_sb: cover property (standby_out);
  c_inv: cover property (lane_invert_out);
  c_wr: cover property (i2c_mode_out && i2c_cfg_wr_in);
endmodule : strap_config_monitor

bind strap_config_decoder strap_config_monitor mon (.*);

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
  import strap_config_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic op_enable_in = 1'b0;
  logic sig_detect_enable_in = 1'b0;
  logic control_mode_select_in = 1'b0;
  logic input_clock_valid_in = 1'b1;
  logic retimer_mode_in = 1'b0;
  logic rate_above_2g_in = 1'b0;
  logic i2c_sda_drive_low_in = 1'b0;
  logic i2c_cfg_wr_in = 1'b0;
  i2c_cfg_s i2c_cfg_in = I2C_CFG_RESET;
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  logic [1:0] addr = 2'h0;
  tri_e lv [4] = '{default: TRI_MID};
  tri_sense_s sense [4];
  tri_sense_s deemph_select_in, equalizer_select_addr_low_in;
  tri_sense_s transmit_termination_select_in, lane_swap_polarity_select_in;
  logic address_bit_high_in, local_ctrl_clock_in, local_ctrl_data_in;
  logic local_ctrl_clock_out, local_ctrl_clock_oe_n_out, local_ctrl_data_out, local_ctrl_data_oe_n_out;
  logic i2c_scl_out, i2c_sda_out, power_down_out, standby_out, detector_on_out, rx_term_on_out;
  logic strap_reserved_out, tx_term_on_out, lane_swap_out, lane_invert_out, i2c_mode_out;
  deemph_e deemph_out;
  eq_mode_e eq_mode_out;
  logic [1:0] i2c_addr_out;
  i2c_cfg_s cfg_exp;
  logic [7:0] held;
  int seed = 32'h7bfb692a;
  int fails = 0;
  int checked = 0;
  wire logic [7:0] set_vec = {deemph_out, eq_mode_out, strap_reserved_out, tx_term_on_out, lane_swap_out, lane_invert_out};
  // Open-drain pins: pulled up unless someone pulls low
  assign local_ctrl_clock_in = scl_drv && local_ctrl_clock_oe_n_out !== 1'b0;
  assign local_ctrl_data_in = sda_drv && local_ctrl_data_oe_n_out !== 1'b0;
  assign {deemph_select_in, equalizer_select_addr_low_in} = {sense[0], sense[1]};
  assign {transmit_termination_select_in, lane_swap_polarity_select_in} = {sense[2], sense[3]};
  strap_config_decoder uut (.*);
  strap_board board (.clk_in(clk_sys_in), .port_mode_in(control_mode_select_in), .addr_in(addr), .lvl_in(lv),
    .addr_hi_out(address_bit_high_in), .sense_out(sense));
  always #50 clk_sys_in = ~clk_sys_in;
  ////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checked++;
    if (got !== want)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic give_verdict();
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  function automatic logic [7:0] exp_set();
    deemph_e d;
    eq_mode_e q;
    d = lv[0] == TRI_LOW ? DEEMPH_NEG2DB : DEEMPH_0DB;
    q = lv[1] == TRI_LOW ? EQ_FIXED_7P5DB : lv[1] == TRI_HIGH ? EQ_FIXED_14DB : EQ_ADAPTIVE;
    if (control_mode_select_in)
    begin
      d = cfg_exp.deemph;
      q = cfg_exp.eq;
    end
    return {d, q, !control_mode_select_in && lv[0] == TRI_HIGH,
      lv[2] == TRI_LOW || lv[2] == TRI_MID && rate_above_2g_in, lv[3] == TRI_LOW, lv[3] == TRI_HIGH && retimer_mode_in};
  endfunction : exp_set
  ////////////////////
  initial
  begin
    cyc(4);
    sys_rst_in = 1'b0;
    chk({power_down_out, set_vec}, 16'h0100);
    for (int n = 0; n < 24; n++)
    begin
      foreach (lv[i])
        lv[i] = tri_e'(3'h1 << (n < 3 ? n : {$random(seed)} % 3));
      {control_mode_select_in, rate_above_2g_in, retimer_mode_in, addr} = 5'($random(seed));
      cfg_exp = I2C_CFG_RESET;
      op_enable_in = 1'b1;
      cyc(30);
      chk({power_down_out, i2c_mode_out}, {1'b0, control_mode_select_in});
      chk(set_vec, exp_set());
      if (control_mode_select_in)
        chk(i2c_addr_out, addr);
      {rate_above_2g_in, retimer_mode_in} = ~{rate_above_2g_in, retimer_mode_in};
      cyc(2);
      chk(set_vec, exp_set());
      i2c_cfg_wr_in = 1'b1;
      repeat (2)
      begin
        i2c_cfg_in = '{deemph: deemph_e'(2'({$random(seed)} % 2)), eq: eq_mode_e'(2'({$random(seed)} % 3))};
        cfg_exp = control_mode_select_in ? i2c_cfg_in : cfg_exp;
        cyc(1);
      end
      i2c_cfg_wr_in = 1'b0;
      cyc(3);
      chk(set_vec, exp_set());
      {scl_drv, sda_drv, i2c_sda_drive_low_in} = 3'($random(seed));
      cyc(5);
      held = control_mode_select_in ? {scl_drv, sda_drv && !i2c_sda_drive_low_in, !i2c_sda_drive_low_in} : 8'h07;
      chk({i2c_scl_out, i2c_sda_out, local_ctrl_data_oe_n_out}, held);
      chk({local_ctrl_clock_out, local_ctrl_clock_oe_n_out, local_ctrl_data_out}, 3'h2);
      {sig_detect_enable_in, input_clock_valid_in} = 2'h2;
      cyc(5);
      chk({standby_out, rx_term_on_out, detector_on_out}, 3'h5);
      input_clock_valid_in = 1'b1;
      cyc(5);
      chk({standby_out, rx_term_on_out, detector_on_out}, 3'h3);
      {sig_detect_enable_in, input_clock_valid_in} = 2'h0;
      cyc(5);
      chk({standby_out, rx_term_on_out, detector_on_out}, 3'h2);
      input_clock_valid_in = 1'b1;
      // Straps moving after the latch must not leak through
      held = exp_set();
      foreach (lv[i])
        lv[i] = tri_e'(3'h1 << ({$random(seed)} % 3));
      cyc(4);
      chk(set_vec, held);
      op_enable_in = 1'b0;
      cyc(5);
      chk({power_down_out, set_vec & 8'hFB}, 16'h0100);
    end
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    fails++;
    give_verdict();
  end
endmodule : tb_top
